// ---- src/bgs_sequencer.sv ----
// buck gate-drive sequencer: switch commands, dead time, refresh and protection inhibits
`timescale 1ns/1ps
`include "bgs_defs.svh"

module bgs_sequencer
   import bgs_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire bgs_pins_s pins,
   input wire logic [15:0] charge_limit_ma,
   output logic hs_cmd,
   output logic ls_cmd,
   output logic discharge_sink_en,
   output logic [15:0] avg_oc_limit_ma,
   output logic period_start
);

   localparam int NPIN = $bits(bgs_pins_s);
   localparam bgs_cnt_t PERIOD_LAST = bgs_cnt_t'(`BGS_PERIOD_CYC - 1);
   localparam bgs_cnt_t DEAD_LOAD = bgs_cnt_t'(`BGS_DEAD_CYC - 1);
   localparam bgs_cnt_t PULSE_LOAD = bgs_cnt_t'(`BGS_PULSE_CYC - 1);
   localparam logic [2:0] BOOT_LIMIT = 3'(`BGS_BOOT_CYCLES);

   // ==========================================================
   // input synchronisers
   logic [NPIN-1:0] sync_a;
   logic [NPIN-1:0] sync_b;
   bgs_pins_s pin;

   // two flops per indication, first stage read only by second
   // a pin may change at any time; the second flop absorbs any metastable settling
   generate
      for (genvar i = 0; i < NPIN; i++) begin : g_sync
         always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               sync_a[i] <= 1'b0;
               sync_b[i] <= 1'b0;
            end else begin
               sync_a[i] <= pins[i];
               sync_b[i] <= sync_a[i];
            end
         end
      end
   endgenerate

   assign pin = bgs_pins_s'(sync_b);

   // ==========================================================
   // period counter
   bgs_cnt_t per_cnt;
   bgs_cnt_t next_per_cnt;
   logic next_period_start;

   // wraps every switching period, pulse marks the start
   always_comb begin
      if (per_cnt == PERIOD_LAST) begin
         next_per_cnt = '0;
      end else begin
         next_per_cnt = per_cnt + bgs_cnt_t'(1);
      end
      next_period_start = (per_cnt == PERIOD_LAST);
   end

   // period registers, restarting from zero after reset
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         per_cnt <= '0;
         period_start <= 1'b0;
      end else begin
         per_cnt <= next_per_cnt;
         period_start <= next_period_start;
      end
   end

   // ==========================================================
   // compare settling
   logic ontime_valid;

   // the compare input lags each period start by the synchroniser and the far side,
   // so a low level seen before then still belongs to the last period
   assign ontime_valid = (per_cnt >= bgs_cnt_t'(`BGS_SYNC_CYC));

   // ==========================================================
   // sequencer state
   bgs_state_e state;
   bgs_state_e next_state;
   bgs_cnt_t tmr;
   bgs_cnt_t next_tmr;
   logic [2:0] boot_cnt;
   logic [2:0] next_boot_cnt;
   logic refresh_armed;
   logic next_refresh_armed;
   logic peak_latch;
   logic next_peak_latch;
   logic ovp_inh;
   logic next_ovp_inh;
   logic hs_ok;
   logic start_hs;
   logic refresh_due;
   logic tmr_done;

   // permission to turn the high side on in this period
   // peak and average trips act on the synchronised pin without waiting for a latch
   assign hs_ok = !peak_latch && !pin.peak_oc && !pin.avg_oc && !ovp_inh;
   assign start_hs = hs_ok && !pin.zero_duty;
   assign refresh_due = (boot_cnt > BOOT_LIMIT);
   assign tmr_done = (tmr == '0);

   // next-state, timers and cycle latches
   always_comb begin
      next_state = state;
      next_tmr = tmr_done ? tmr : tmr - bgs_cnt_t'(1);
      next_boot_cnt = boot_cnt;
      next_refresh_armed = refresh_armed | !pin.boot_low;
      // peak latch: a trip in the start cycle still wins over rearm
      next_peak_latch = (peak_latch && !period_start) || pin.peak_oc;
      // over-voltage hysteresis
      if (pin.fb_over_hi) begin
         next_ovp_inh = 1'b1;
      end else if (pin.fb_under_lo) begin
         next_ovp_inh = 1'b0;
      end else begin
         next_ovp_inh = ovp_inh;
      end
      // count consecutive periods with bootstrap low
      if (period_start) begin
         if (!pin.boot_low) begin
            next_boot_cnt = '0;
         end else if (!refresh_due) begin
            next_boot_cnt = boot_cnt + 3'h1;
         end
      end
      case (state)
         BGS_IDLE: begin
            if (period_start) begin
               if (start_hs) begin
                  next_state = BGS_HS;
               end else if (pin.zero_duty && pin.boot_low && refresh_armed) begin
                  next_state = BGS_REF_LS;
                  next_tmr = PULSE_LOAD;
                  next_refresh_armed = 1'b0;
               end
            end
         end
         BGS_HS: begin
            if (!hs_ok) begin
               next_state = BGS_DEAD_HL;
               next_tmr = DEAD_LOAD;
            end else if (refresh_due) begin
               next_state = BGS_REF_DEAD;
               next_tmr = DEAD_LOAD;
               next_boot_cnt = '0;
            end else if (ontime_valid && !pin.pwm_on && !pin.full_duty) begin
               next_state = BGS_DEAD_HL;
               next_tmr = DEAD_LOAD;
            end
         end
         BGS_DEAD_HL: begin
            if (period_start) begin
               next_state = BGS_DEAD_LH; // finish dead time, then decide
            end else if (tmr_done) begin
               next_state = BGS_LS_BLANK;
               next_tmr = PULSE_LOAD;
            end
         end
         BGS_LS_BLANK: begin
            if (period_start) begin
               next_state = BGS_DEAD_LH;
               next_tmr = DEAD_LOAD;
            end else if (tmr_done) begin
               // comparator ignored until blanking ends
               next_state = pin.under_current_cutoff ? BGS_LS_CUT : BGS_LS_ON;
               next_tmr = DEAD_LOAD; // owed if the cut lands just before a period start
            end
         end
         BGS_LS_ON: begin
            if (period_start) begin
               next_state = BGS_DEAD_LH;
               next_tmr = DEAD_LOAD;
            end else if (pin.under_current_cutoff) begin
               next_state = BGS_LS_CUT;
               next_tmr = DEAD_LOAD;
            end
         end
         BGS_LS_CUT: begin
            // low side held off until the next period start; a cut just before
            // the start still owes the rest of its dead time to the high side
            if (period_start) begin
               if (tmr_done) begin
                  next_state = start_hs ? BGS_HS : BGS_IDLE;
               end else begin
                  next_state = BGS_DEAD_LH;
               end
            end
         end
         BGS_DEAD_LH: begin
            if (tmr_done) begin
               next_state = start_hs ? BGS_HS : BGS_IDLE;
            end
         end
         BGS_REF_DEAD: begin
            if (tmr_done) begin
               next_state = BGS_REF_LS;
               next_tmr = PULSE_LOAD;
            end
         end
         BGS_REF_LS: begin
            if (tmr_done) begin
               next_state = BGS_REF_BACK;
               next_tmr = DEAD_LOAD;
            end
         end
         BGS_REF_BACK: begin
            if (tmr_done) begin
               next_state = start_hs ? BGS_HS : BGS_IDLE;
            end
         end
         default: begin
            // unused encodings fall back to idle with both commands off
            next_state = BGS_IDLE;
            next_tmr = '0;
         end
      endcase
   end

   // state registers; reset parks the sequencer idle with every latch clear except refresh_armed, which starts set
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= BGS_IDLE;
         tmr <= '0;
         boot_cnt <= '0;
         refresh_armed <= 1'b1;
         peak_latch <= 1'b0;
         ovp_inh <= 1'b0;
      end else begin
         state <= next_state;
         tmr <= next_tmr;
         boot_cnt <= next_boot_cnt;
         refresh_armed <= next_refresh_armed;
         peak_latch <= next_peak_latch;
         ovp_inh <= next_ovp_inh;
      end
   end

   // ==========================================================
   // registered outputs
   logic next_hs_cmd;
   logic next_ls_cmd;
   logic next_sink_en;
   logic [15:0] next_avg_oc_limit_ma;
   logic [31:0] scaled_ma;

   // commands decode from the next state; high side also cut at once on a trip
   always_comb begin
      next_hs_cmd = (next_state == BGS_HS) && !pin.peak_oc;
      next_ls_cmd = (next_state == BGS_LS_BLANK) || (next_state == BGS_LS_ON)
         || (next_state == BGS_REF_LS);
      next_sink_en = pin.charging_active;
      // the average limit saturates at the width of its output
      scaled_ma = (32'(charge_limit_ma) * 32'(`BGS_AOC_PCT)) / 32'h0000_0064;
      if (charge_limit_ma < 16'(`BGS_AOC_KNEE_MA)) begin
         next_avg_oc_limit_ma = 16'(`BGS_AOC_FLOOR_MA);
      end else if (scaled_ma > 32'h0000_FFFF) begin
         next_avg_oc_limit_ma = 16'hFFFF;
      end else begin
         next_avg_oc_limit_ma = scaled_ma[15:0];
      end
   end

   // outputs registered so the drivers never see decode glitches
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         hs_cmd <= 1'b0;
         ls_cmd <= 1'b0;
         discharge_sink_en <= 1'b0;
         avg_oc_limit_ma <= 16'h0000;
      end else begin
         hs_cmd <= next_hs_cmd;
         ls_cmd <= next_ls_cmd;
         discharge_sink_en <= next_sink_en;
         avg_oc_limit_ma <= next_avg_oc_limit_ma;
      end
   end

endmodule

// ---- common/bgs_defs.svh ----
// timing counts and thresholds for the buck gate-drive sequencer
`ifndef BGS_DEFS_SVH
`define BGS_DEFS_SVH
`define BGS_CLK_HZ 200000000
`define BGS_SW_HZ 700000
`define BGS_PERIOD_CYC (`BGS_CLK_HZ / `BGS_SW_HZ)
`define BGS_DEAD_NS 25
`define BGS_DEAD_CYC ((`BGS_DEAD_NS * (`BGS_CLK_HZ / 1000000) + 999) / 1000)
`define BGS_PULSE_NS 40
`define BGS_PULSE_CYC ((`BGS_PULSE_NS * (`BGS_CLK_HZ / 1000000) + 999) / 1000)
`define BGS_BOOT_CYCLES 3
`define BGS_SYNC_CYC 3
`define BGS_AOC_PCT 145
`define BGS_AOC_KNEE_MA 3300
`define BGS_AOC_FLOOR_MA 5000
`endif

// ---- common/bgs_pkg.sv ----
// types shared by the buck gate-drive sequencer
package bgs_pkg;
   // comparator and pin indications, all asynchronous to clk
   typedef struct packed {
      logic pwm_on;
      logic full_duty;
      logic zero_duty;
      logic boot_low;
      logic under_current_cutoff;
      logic peak_oc;
      logic avg_oc;
      logic fb_over_hi;
      logic fb_under_lo;
      logic charging_active;
   } bgs_pins_s;

   typedef enum logic [3:0] {
      BGS_IDLE,
      BGS_HS,
      BGS_DEAD_HL,
      BGS_LS_BLANK,
      BGS_LS_ON,
      BGS_LS_CUT,
      BGS_DEAD_LH,
      BGS_REF_DEAD,
      BGS_REF_LS,
      BGS_REF_BACK
   } bgs_state_e;

   typedef logic [8:0] bgs_cnt_t;
endpackage

// ---- dv/bgs_seq_properties.sv ----
// port checker for the gate-drive sequencer
`timescale 1ns/1ps
module bgs_seq_properties
   import bgs_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire bgs_pins_s pins,
   input wire logic [15:0] charge_limit_ma,
   input wire logic hs_cmd,
   input wire logic ls_cmd,
   input wire logic discharge_sink_en,
   input wire logic [15:0] avg_oc_limit_ma,
   input wire logic period_start
);
   logic [8:0] pcnt;
   logic [31:0] pct;
   logic [15:0] lim;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   // clocks since the last period start
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) pcnt <= 9'h1FF; // first start after reset comes one clk later
      else pcnt <= period_start ? 9'h000 : pcnt + 9'h001;
   end
   // expected average over-current limit
   assign pct = {16'h0000, charge_limit_ma} * 32'h0000_0091 / 32'h0000_0064;
   assign lim = (charge_limit_ma < 16'h0CE4) ? 16'h1388 :
      ((pct > 32'h0000_FFFF) ? 16'hFFFF : pct[15:0]);
   period_len_a: assert property (pcnt == 9'h11C |-> period_start)
      else $error("period start missing");
   no_overlap_a: assert property (!(hs_cmd && ls_cmd))
      else $error("both commands high");
   dead_hl_a: assert property ($fell(hs_cmd) |-> !ls_cmd [*5])
      else $error("short dead time after high side");
   dead_lh_a: assert property ($fell(ls_cmd) |-> !hs_cmd [*5])
      else $error("short dead time after low side");
   ls_blank_a: assert property ($rose(ls_cmd) |-> ls_cmd [*8])
      else $error("low side pulse too short");
   peak_off_a: assert property ($rose(pins.peak_oc) |-> ##3 !hs_cmd)
      else $error("high side not cut by peak trip");
   avg_off_a: assert property (pins.avg_oc [*4] |-> !hs_cmd)
      else $error("high side on during average trip");
   ovp_off_a: assert property (pins.fb_over_hi [*5] |-> !hs_cmd)
      else $error("high side on during over-voltage");
   avg_lim_a: assert property ($past(rst_b) |-> avg_oc_limit_ma == $past(lim))
      else $error("average limit wrong");
   sink_en_a: assert property (discharge_sink_en == $past(pins.charging_active, 3))
      else $error("sink enable wrong");
   cover property ($rose(ls_cmd));
   cover property (period_start && pins.full_duty && hs_cmd);
   cover property ($fell(hs_cmd) && pins.peak_oc);
endmodule

// ---- dv/bgs_comparators.sv ----
// compare and comparator model on the far side
`timescale 1ns/1ps
module bgs_comparators
   import bgs_pkg::*;
(
   input wire logic clk,
   input wire logic period_start,
   input wire bgs_pins_s req,
   input wire logic [8:0] on_cyc,
   output bgs_pins_s pins = '0
);
   logic [8:0] cnt = 9'h000;
   bgs_pins_s nxt;
   // compare stays high for on_cyc clocks from each period start
   always @(negedge clk) begin
      cnt = period_start ? 9'h000 : cnt + 9'h001;
      nxt = req;
      nxt.pwm_on = (cnt < on_cyc);
      pins <= nxt;
   end
endmodule

// ---- dv/testbench.sv ----
// self-checking bench for the gate-drive sequencer
`timescale 1ns/1ps
module testbench;
   import bgs_pkg::*;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   bgs_pins_s req = '0;
   bgs_pins_s pins;
   logic [8:0] on_cyc = 9'h064;
   logic [15:0] lim_ma = 16'h0000;
   logic hs, ls, sink, pst;
   logic ls_q = 1'b0;
   logic [15:0] aoc;
   int miscompares = 0;
   int num_checks = 0;
   int hs_n = 0;
   int ls_n = 0;
   initial forever #2.5 clk = ~clk;
   bgs_sequencer i_bgs_sequencer (.clk(clk), .rst_b(rst_b), .pins(pins),
      .charge_limit_ma(lim_ma), .hs_cmd(hs), .ls_cmd(ls), .discharge_sink_en(sink),
      .avg_oc_limit_ma(aoc), .period_start(pst));
   bgs_comparators i_bgs_comparators (.clk(clk), .period_start(pst), .req(req),
      .on_cyc(on_cyc), .pins(pins));
   // high-side clocks and low-side entries
   always @(posedge clk) begin
      hs_n = hs_n + hs;
      ls_n = ls_n + (ls && !ls_q);
      ls_q = ls;
   end
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         miscompares++;
         $display("MISMATCH %s expected %0d seen %0d", nm, e, g);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // waits for n period starts under a bound
   task automatic per(int n);
      int k;
      k = 0;
      while (n > 0) begin
         @(negedge clk);
         k++;
         if (pst === 1'b1) n--;
         if (k > 3000) begin
            chk("timeout", 0, 1);
            end_sim();
         end
      end
   endtask
   // settles, then counts over n periods
   task automatic meas(int n);
      per(2);
      hs_n = 0;
      ls_n = 0;
      per(n);
   endtask
   task automatic t_ccm();
      meas(1);
      chk("hs_on", 1, hs_n > 90 && hs_n < 110);
      chk("ls_at_end", 1, ls);
      req.under_current_cutoff = 1'b1;
      meas(1);
      chk("ls_cut", 0, ls);
      chk("ls_blank", 1, ls_n);
      req.under_current_cutoff = 1'b0;
   endtask
   task automatic t_zero();
      req.zero_duty = 1'b1;
      on_cyc = 9'h000;
      meas(1);
      chk("zero_hs", 0, hs_n);
      chk("zero_ls", 0, ls_n);
      req.boot_low = 1'b1;
      hs_n = 0;
      ls_n = 0;
      per(3);
      chk("zero_refresh", 1, ls_n);
      chk("zero_refresh_hs", 0, hs_n);
      req = '0;
   endtask
   task automatic t_full();
      req.full_duty = 1'b1;
      on_cyc = 9'h1FF;
      meas(1);
      chk("full_hs", 285, hs_n);
      req.boot_low = 1'b1;
      meas(5);
      chk("refresh", 1, ls_n > 0);
      chk("full_back", 1, hs);
      req = '0;
      on_cyc = 9'h064;
   endtask
   task automatic t_inhibit();
      req.avg_oc = 1'b1;
      meas(1);
      chk("avg_hold", 0, hs_n);
      req.avg_oc = 1'b0;
      meas(1);
      chk("avg_resume", 1, hs_n > 0);
      req.fb_over_hi = 1'b1;
      per(1);
      req.fb_over_hi = 1'b0;
      meas(1);
      chk("ovp_hyst", 0, hs_n);
      req.fb_under_lo = 1'b1;
      meas(1);
      chk("ovp_resume", 1, hs_n > 0);
      req.fb_under_lo = 1'b0;
   endtask
   task automatic t_peak();
      per(1);
      hs_n = 0;
      repeat (20) @(negedge clk);
      req.peak_oc = 1'b1;
      repeat (10) @(negedge clk);
      req.peak_oc = 1'b0;
      per(1);
      chk("peak_latch", 1, hs_n < 26);
      repeat (8) @(negedge clk);
      chk("peak_rearm", 1, hs);
   endtask
   task automatic t_lim();
      logic [15:0] tab [4] = '{16'h03E8, 16'h0CE3, 16'h0CE4, 16'hFFFF};
      logic [31:0] e;
      foreach (tab[i]) begin
         lim_ma = tab[i];
         e = (tab[i] < 16'h0CE4) ? 32'h0000_1388 : tab[i] * 32'h0000_0091 / 32'h0000_0064;
         repeat (2) @(negedge clk);
         chk("avg_limit", (e > 32'h0000_FFFF) ? 32'h0000_FFFF : e, aoc);
      end
   endtask
   task automatic t_sink();
      req.charging_active = 1'b1;
      repeat (4) @(negedge clk);
      chk("sink_on", 1, sink);
      req.charging_active = 1'b0;
      repeat (4) @(negedge clk);
      chk("sink_off", 0, sink);
   endtask
   // main sequence
   initial begin
      repeat (6) @(negedge clk);
      chk("reset_cmds", 0, {hs, ls, sink});
      rst_b = 1'b1;
      t_ccm();
      t_zero();
      t_full();
      t_inhibit();
      t_peak();
      t_lim();
      t_sink();
      end_sim();
   end
endmodule
bind bgs_sequencer bgs_seq_properties i_props (.clk(clk), .rst_b(rst_b), .pins(pins),
   .charge_limit_ma(charge_limit_ma), .hs_cmd(hs_cmd), .ls_cmd(ls_cmd),
   .discharge_sink_en(discharge_sink_en), .avg_oc_limit_ma(avg_oc_limit_ma),
   .period_start(period_start));
